// *** common/do_route_pkg.sv ***
// Purpose: constants for the digital output routing logic
// Assumes: 50 MHz pclk, APB register access
// Notes: cycle lengths are held in whole seconds
// Behaviour
// - With a relay target, cycle length is accepted only from 5 to 120 s.
// - Without a relay target, cycle length is accepted from 1 to 120 s.
// - Mode 0 tracks demand; mode 1 switches at most once per cycle.
// - First cycle length resets to 10 s for relay output 1, else 2 s.
// - Second cycle length resets to 10 s on single-output variants, else 2 s.
// - One cycle mode setting governs both manipulated outputs.
// - Primary output routed by source code 1 to relay or event runs at least 5 s cycle.
// - Cooling output routed by source code 2 to relay or event runs at least 5 s cycle.
// - Source code 0 default, 1 primary, 2 cooling; selectors reset to 0.
// - Source code 3 drives (A and B) or (C and D).
// - Source code 4 drives (A or B) and (C or D).
// - Source code 5 drives the OR of all four slots.
// - Source code 6 drives the AND of all four slots.
// - Default: control outputs follow primary and cooling output status.
// - Default: event outputs follow internal events one to three.
// - Slot code 0 supplies constant 0, code 1 constant 1.
// - Slot codes 2 to 6 supply internal events one to five.
// - Slot codes 14, 15, 18, 19: primary, cooling, digital inputs.
// - Slot codes 26-28 internal contacts, 34-37 communication inputs.
// - Slot code 38 manual-mode flag, 39 ready-mode flag.
package do_route_pkg;
    localparam int NUM_OUT = 5;
    localparam int NUM_SLOT = 4;
    localparam int SEL_W = 3;
    localparam int SLOT_W = 6;
    localparam int CYC_W = 7;
    localparam int PCT_W = 7;
    // Register byte offsets
    localparam logic [11:0] CYCLE1_OFS = 12'h000;
    localparam logic [11:0] CYCLE2_OFS = 12'h004;
    localparam logic [11:0] MODE_OFS = 12'h008;
    localparam logic [11:0] SOURCE_OFS = 12'h00c;
    localparam logic [11:0] SLOT_BASE_OFS = 12'h010;
    localparam logic [11:0] DEMAND_OFS = 12'h024;
    localparam logic [11:0] STATUS_OFS = 12'h028;
    // Cycle limits in seconds, full-scale demand in percent
    localparam logic [6:0] CYC_MAX = 7'd120;
    localparam logic [6:0] CYC_MIN_RELAY = 7'd5;
    localparam logic [6:0] CYC_MIN_PLAIN = 7'd1;
    localparam logic [6:0] CYC_RST_RELAY = 7'd10;
    localparam logic [6:0] CYC_RST_PLAIN = 7'd2;
    localparam logic [6:0] PCT_FULL = 7'd100;
    // Source selector codes
    localparam logic [2:0] SRC_DEFAULT = 3'h0;
    localparam logic [2:0] SRC_PRIMARY = 3'h1;
    localparam logic [2:0] SRC_COOLING = 3'h2;
    localparam logic [2:0] SRC_FUNC1 = 3'h3;
    localparam logic [2:0] SRC_FUNC2 = 3'h4;
    localparam logic [2:0] SRC_FUNC3 = 3'h5;
    localparam logic [2:0] SRC_FUNC4 = 3'h6;
    // Slot codes
    localparam logic [5:0] SLOT_OFF = 6'h00;
    localparam logic [5:0] SLOT_ON = 6'h01;
    localparam logic [5:0] SLOT_EVT1 = 6'h02;
    localparam logic [5:0] SLOT_PRIMARY = 6'h0e;
    localparam logic [5:0] SLOT_COOLING = 6'h0f;
    localparam logic [5:0] SLOT_DI1 = 6'h12;
    localparam logic [5:0] SLOT_DI2 = 6'h13;
    localparam logic [5:0] SLOT_CONTACT1 = 6'h1a;
    localparam logic [5:0] SLOT_COMM1 = 6'h22;
    localparam logic [5:0] SLOT_MANUAL = 6'h26;
    localparam logic [5:0] SLOT_READY = 6'h27;
    // Timing
    localparam int CLK_HZ = 50000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
endpackage

// *** logic/do_output_mux.sv ***
// Purpose: one output's slot selection and source combination
// Assumes: all inputs on pclk domain
// Notes: purely combinational
`timescale 1ns/100ps
module do_output_mux (
    input wire logic [2:0] source_sel,
    input wire logic [23:0] slot_sel,
    input wire logic default_bit,
    input wire logic primary_bit,
    input wire logic cooling_bit,
    input wire logic [39:0] pool,
    output logic result
);
    logic [3:0] slot;
    always_comb begin
        for (int i = 0; i < do_route_pkg::NUM_SLOT; i++) begin
            // Pool is indexed by slot code; undefined codes hold 0
            if (slot_sel[i*6 +: 6] <= do_route_pkg::SLOT_READY) begin
                slot[i] = pool[slot_sel[i*6 +: 6]];
            end else begin
                slot[i] = 1'b0;
            end
        end
        case (source_sel)
            do_route_pkg::SRC_DEFAULT: result = default_bit;
            do_route_pkg::SRC_PRIMARY: result = primary_bit;
            do_route_pkg::SRC_COOLING: result = cooling_bit;
            do_route_pkg::SRC_FUNC1:
                result = (slot[0] & slot[1]) | (slot[2] & slot[3]);
            do_route_pkg::SRC_FUNC2:
                result = (slot[0] | slot[1]) & (slot[2] | slot[3]);
            do_route_pkg::SRC_FUNC3: result = |slot;
            do_route_pkg::SRC_FUNC4: result = &slot;
            default: result = 1'b0;
        endcase
    end
endmodule

// *** logic/do_route.sv ***
// Purpose: time-proportioned outputs and digital output routing
// Assumes: APB slave, 50 MHz pclk, straps stable after reset
// Notes: registers hold selectors, cycle lengths, mode and demands
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module do_route #(
    parameter int TICK_CYCLES = do_route_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic out1_is_relay,
    input wire logic out2_is_relay,
    input wire logic single_output_variant,
    input wire logic [4:0] internal_event,
    input wire logic digital_input_one,
    input wire logic digital_input_two,
    input wire logic [2:0] internal_contact,
    input wire logic [3:0] comm_input,
    input wire logic manual_mode,
    input wire logic ready_mode,
    output logic [1:0] control_out,
    output logic [2:0] event_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] cyc1;
        logic [6:0] cyc2;
        logic mode;
        logic [14:0] src;
        logic [119:0] slots;
        logic [6:0] dem1;
        logic [6:0] dem2;
        logic strap_done;
        logic [2:0] di1_sync;
        logic [2:0] di2_sync;
        logic di1;
        logic di2;
        logic [22:0] tick_cnt;
        logic [6:0] sub_cnt;
        logic [6:0] sec1;
        logic [6:0] sec2;
        logic [6:0] run1;
        logic [6:0] run2;
        logic [6:0] dem1_lat;
        logic [6:0] dem2_lat;
        logic mv1;
        logic mv2;
        logic off1;
        logic off2;
        logic [1:0] ctl;
        logic [2:0] evt;
        logic [31:0] rdata;
    } state_t;
    state_t st_reg, st_next;

    logic [39:0] pool;
    logic [4:0] mux_out;
    logic [4:0] is_relay_out;
    logic mv1_on_relay, mv2_on_relay;
    logic [6:0] min1, min2;
    logic [6:0] eff1, eff2;
    logic write_en;
    logic tick, sec_tick;
    logic [20:0] on1_t, on2_t, pos1_t, pos2_t;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_reg.rdata;
    assign control_out = st_reg.ctl;
    assign event_out = st_reg.evt;
    assign write_en = psel & penable & pwrite;

    // ------------------------------------------------------------
    // Slot pool
    // ------------------------------------------------------------
    always_comb begin
        pool = '0;
        pool[do_route_pkg::SLOT_ON] = 1'b1;
        pool[do_route_pkg::SLOT_EVT1 +: 5] = internal_event;
        pool[do_route_pkg::SLOT_PRIMARY] = st_reg.mv1;
        pool[do_route_pkg::SLOT_COOLING] = st_reg.mv2;
        pool[do_route_pkg::SLOT_DI1] = st_reg.di1;
        pool[do_route_pkg::SLOT_DI2] = st_reg.di2;
        pool[do_route_pkg::SLOT_CONTACT1 +: 3] = internal_contact;
        pool[do_route_pkg::SLOT_COMM1 +: 4] = comm_input;
        pool[do_route_pkg::SLOT_MANUAL] = manual_mode;
        pool[do_route_pkg::SLOT_READY] = ready_mode;
    end

    // ------------------------------------------------------------
    // Output selectors
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < do_route_pkg::NUM_OUT; g++) begin : g_out
            logic dflt;
            if (g == 0) begin : g_c1
                assign dflt = st_reg.mv1;
            end else if (g == 1) begin : g_c2
                assign dflt = st_reg.mv2;
            end else begin : g_ev
                assign dflt = internal_event[g-2];
            end
            do_output_mux u_mux (
                .source_sel(st_reg.src[g*3 +: 3]),
                .slot_sel(st_reg.slots[g*24 +: 24]),
                .default_bit(dflt),
                .primary_bit(st_reg.mv1),
                .cooling_bit(st_reg.mv2),
                .pool(pool),
                .result(mux_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Cycle limits
    // ------------------------------------------------------------
    assign is_relay_out = {3'b111, out2_is_relay, out1_is_relay};
    always_comb begin
        mv1_on_relay = 1'b0;
        mv2_on_relay = 1'b0;
        for (int i = 0; i < do_route_pkg::NUM_OUT; i++) begin
            if (is_relay_out[i]
                && st_reg.src[i*3 +: 3] == do_route_pkg::SRC_PRIMARY) begin
                mv1_on_relay = 1'b1;
            end
            if (is_relay_out[i]
                && st_reg.src[i*3 +: 3] == do_route_pkg::SRC_COOLING) begin
                mv2_on_relay = 1'b1;
            end
        end
        min1 = out1_is_relay ? do_route_pkg::CYC_MIN_RELAY
                             : do_route_pkg::CYC_MIN_PLAIN;
        min2 = out2_is_relay ? do_route_pkg::CYC_MIN_RELAY
                             : do_route_pkg::CYC_MIN_PLAIN;
        eff1 = st_reg.cyc1;
        eff2 = st_reg.cyc2;
        if (mv1_on_relay && eff1 < do_route_pkg::CYC_MIN_RELAY) begin
            eff1 = do_route_pkg::CYC_MIN_RELAY;
        end
        if (mv2_on_relay && eff2 < do_route_pkg::CYC_MIN_RELAY) begin
            eff2 = do_route_pkg::CYC_MIN_RELAY;
        end
    end

    assign tick = (st_reg.tick_cnt == 23'(TICK_CYCLES - 1));
    assign sec_tick = tick
        && (st_reg.sub_cnt == 7'(do_route_pkg::TICKS_PER_S - 1));
    assign on1_t = 21'(st_reg.dem1_lat * st_reg.run1
        * do_route_pkg::TICKS_PER_S);
    assign on2_t = 21'(st_reg.dem2_lat * st_reg.run2
        * do_route_pkg::TICKS_PER_S);
    assign pos1_t = 21'((st_reg.sec1 * do_route_pkg::TICKS_PER_S
        + st_reg.sub_cnt) * do_route_pkg::PCT_FULL);
    assign pos2_t = 21'((st_reg.sec2 * do_route_pkg::TICKS_PER_S
        + st_reg.sub_cnt) * do_route_pkg::PCT_FULL);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.di1_sync = {st_reg.di1_sync[1:0], digital_input_one};
        st_next.di2_sync = {st_reg.di2_sync[1:0], digital_input_two};
        if (st_reg.di1_sync[1] == st_reg.di1_sync[2]) begin
            st_next.di1 = st_reg.di1_sync[2];
        end
        if (st_reg.di2_sync[1] == st_reg.di2_sync[2]) begin
            st_next.di2 = st_reg.di2_sync[2];
        end
        // Reset values caught once after release
        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'b1;
            st_next.cyc1 = out1_is_relay ? do_route_pkg::CYC_RST_RELAY
                                         : do_route_pkg::CYC_RST_PLAIN;
            st_next.cyc2 = single_output_variant
                ? do_route_pkg::CYC_RST_RELAY
                : do_route_pkg::CYC_RST_PLAIN;
        end
        if (write_en) begin
            case (paddr)
                do_route_pkg::CYCLE1_OFS:
                    if (pwdata[6:0] >= min1
                        && pwdata[6:0] <= do_route_pkg::CYC_MAX
                        && pwdata[31:7] == '0) begin
                        st_next.cyc1 = pwdata[6:0];
                    end
                do_route_pkg::CYCLE2_OFS:
                    if (pwdata[6:0] >= min2
                        && pwdata[6:0] <= do_route_pkg::CYC_MAX
                        && pwdata[31:7] == '0) begin
                        st_next.cyc2 = pwdata[6:0];
                    end
                do_route_pkg::MODE_OFS: st_next.mode = pwdata[0];
                do_route_pkg::SOURCE_OFS: st_next.src = pwdata[14:0];
                do_route_pkg::DEMAND_OFS: begin
                    if (pwdata[6:0] <= do_route_pkg::PCT_FULL) begin
                        st_next.dem1 = pwdata[6:0];
                    end
                    if (pwdata[14:8] <= do_route_pkg::PCT_FULL) begin
                        st_next.dem2 = pwdata[14:8];
                    end
                end
                default: begin
                    for (int i = 0; i < do_route_pkg::NUM_OUT; i++) begin
                        if (paddr == do_route_pkg::SLOT_BASE_OFS
                            + 12'(4 * i)) begin
                            st_next.slots[i*24 +: 24] = pwdata[23:0];
                        end
                    end
                end
            endcase
        end
        // Read data captured in setup phase
        if (psel && !penable) begin
            st_next.rdata = '0;
            case (paddr)
                do_route_pkg::CYCLE1_OFS: st_next.rdata[6:0] = st_reg.cyc1;
                do_route_pkg::CYCLE2_OFS: st_next.rdata[6:0] = st_reg.cyc2;
                do_route_pkg::MODE_OFS: st_next.rdata[0] = st_reg.mode;
                do_route_pkg::SOURCE_OFS: st_next.rdata[14:0] = st_reg.src;
                do_route_pkg::DEMAND_OFS:
                    st_next.rdata[14:0] = {st_reg.dem2, 1'b0,
                                           st_reg.dem1};
                do_route_pkg::STATUS_OFS:
                    st_next.rdata[20:0] = {st_reg.sec2, st_reg.sec1,
                        st_reg.mv2, st_reg.mv1, st_reg.evt, st_reg.ctl};
                default: begin
                    for (int i = 0; i < do_route_pkg::NUM_OUT; i++) begin
                        if (paddr == do_route_pkg::SLOT_BASE_OFS
                            + 12'(4 * i)) begin
                            st_next.rdata[23:0] = st_reg.slots[i*24 +: 24];
                        end
                    end
                end
            endcase
        end
        // Time base
        st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 23'd1;
        if (tick) begin
            st_next.sub_cnt = sec_tick ? '0 : st_reg.sub_cnt + 7'd1;
        end
        if (sec_tick) begin
            st_next.sec1 = st_reg.sec1 + 7'd1;
            st_next.sec2 = st_reg.sec2 + 7'd1;
            if (st_reg.sec1 + 7'd1 >= st_reg.run1) begin
                st_next.sec1 = '0;
                st_next.run1 = eff1;
                st_next.dem1_lat = st_reg.dem1;
                st_next.off1 = 1'b0;
            end
            if (st_reg.sec2 + 7'd1 >= st_reg.run2) begin
                st_next.sec2 = '0;
                st_next.run2 = eff2;
                st_next.dem2_lat = st_reg.dem2;
                st_next.off2 = 1'b0;
            end
        end
        // Duty: demand held per cycle in mode 1, live in mode 0
        if (!st_reg.mode) begin
            st_next.dem1_lat = st_reg.dem1;
            st_next.dem2_lat = st_reg.dem2;
        end
        st_next.mv1 = !st_reg.off1 && pos1_t < on1_t;
        st_next.mv2 = !st_reg.off2 && pos2_t < on2_t;
        if (st_reg.mode && st_reg.mv1 && !(pos1_t < on1_t)) begin
            st_next.off1 = 1'b1;
        end
        if (st_reg.mode && st_reg.mv2 && !(pos2_t < on2_t)) begin
            st_next.off2 = 1'b1;
        end
        st_next.ctl = mux_out[1:0];
        st_next.evt = mux_out[4:2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.cyc1 <= do_route_pkg::CYC_RST_PLAIN;
            st_reg.cyc2 <= do_route_pkg::CYC_RST_PLAIN;
            st_reg.run1 <= do_route_pkg::CYC_RST_PLAIN;
            st_reg.run2 <= do_route_pkg::CYC_RST_PLAIN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cycle_max_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.cyc1 <= do_route_pkg::CYC_MAX
        && st_reg.cyc2 <= do_route_pkg::CYC_MAX)
        else $error("cycle length above limit");
    relay_min_a: assert property (@(posedge pclk) disable iff (!presetn)
        sec_tick && mv1_on_relay |=> st_reg.run1 >= 7'd5 || st_reg.sec1 != 0)
        else $error("relay cycle below five seconds");
    relay_min2_a: assert property (@(posedge pclk) disable iff (!presetn)
        sec_tick && mv2_on_relay |=> st_reg.run2 >= 7'd5 || st_reg.sec2 != 0)
        else $error("cooling relay cycle below five seconds");
    cyc_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        write_en && paddr == do_route_pkg::CYCLE1_OFS && out1_is_relay
        && pwdata < 32'(do_route_pkg::CYC_MIN_RELAY)
        |=> $stable(st_reg.cyc1))
        else $error("short relay cycle accepted");
    reset_cycle_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !st_reg.strap_done && out1_is_relay |=> st_reg.cyc1 == 7'd10)
        else $error("first cycle reset wrong");
    reset_cyc2_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_reg.strap_done && single_output_variant
        |=> st_reg.cyc2 == do_route_pkg::CYC_RST_RELAY)
        else $error("second cycle reset wrong");
    func1_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.src[8:6] == do_route_pkg::SRC_FUNC1 |=> st_reg.evt[0]
        == $past((g_out[2].u_mux.slot[0] & g_out[2].u_mux.slot[1])
        | (g_out[2].u_mux.slot[2] & g_out[2].u_mux.slot[3])))
        else $error("event one function one wrong");
    default_evt_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        st_reg.src[8:6] == 3'h0 |=> st_reg.evt[0] == $past(internal_event[0]))
        else $error("event one default wrong");
    ctl_dflt_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.src[2:0] == do_route_pkg::SRC_DEFAULT
        |=> st_reg.ctl[0] == $past(st_reg.mv1))
        else $error("control output one default wrong");
    ctl_cool_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.src[2:0] == do_route_pkg::SRC_COOLING
        |=> st_reg.ctl[0] == $past(st_reg.mv2))
        else $error("control output one cooling source wrong");
    zero_demand_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        st_reg.dem1_lat == 7'd0 && st_reg.mode == 1'b0 |=> !st_reg.mv1)
        else $error("output on with zero demand");
    once_per_cyc_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        st_reg.off1 |-> !st_reg.mv1 || st_reg.sec1 == 0)
        else $error("second switch in one cycle");
    dem_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.mode && !sec_tick
        |=> $stable({st_reg.dem1_lat, st_reg.dem2_lat}))
        else $error("demand changed inside a cycle");
    mode_write_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        write_en && paddr == do_route_pkg::MODE_OFS
        |=> st_reg.mode == $past(pwdata[0]))
        else $error("mode not stored");
endmodule

// *** sim/relay_driver_model.sv ***
// Purpose: relay or pulse driver standing at the routed outputs
// Assumes: outputs are levels on pclk
// Notes: counts off-to-on switch operations of each output
`timescale 1ns/100ps
module relay_driver_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] drive,
    output int on_count [5]
);
    logic [4:0] last_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg <= 5'h00;
            for (int i = 0; i < 5; i++) begin
                on_count[i] <= 0;
            end
        end else begin
            last_reg <= drive;
            for (int i = 0; i < 5; i++) begin
                if (drive[i] && !last_reg[i]) begin
                    on_count[i] <= on_count[i] + 1;
                end
            end
        end
    end
endmodule

// *** sim/digital_output_routing_logic_test.sv ***
// Purpose: self-checking bench for the output routing block
// Assumes: relay on output 1, plain output 2, two-output variant
// Notes: tick shortened to 2 clocks, so one second is 200 clocks
`timescale 1ns/100ps
module digital_output_routing_logic_test;
    localparam int TICKS = 2;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] internal_event = 5'h00;
    logic digital_input_one = 1'b0, digital_input_two = 1'b0;
    logic [2:0] internal_contact = 3'h0;
    logic [3:0] comm_input = 4'h0;
    logic manual_mode = 1'b0, ready_mode = 1'b0;
    logic out1_relay = 1'b1, out2_relay = 1'b0, single_var = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr;
    logic [1:0] control_out;
    logic [2:0] event_out;
    int on_count [5];
    int err_count = 0, comparisons = 0, cyc = 0;

    do_route #(.TICK_CYCLES(TICKS)) DUT (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .out1_is_relay(out1_relay), .out2_is_relay(out2_relay),
        .single_output_variant(single_var), .internal_event,
        .digital_input_one, .digital_input_two, .internal_contact,
        .comm_input, .manual_mode, .ready_mode, .control_out, .event_out);
    relay_driver_model drv (.pclk, .presetn,
        .drive({event_out, control_out}), .on_count);

    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc >= 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Compared %0d, mismatched %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic slot_m(int c);
        logic [39:0] p;
        p = '0;
        p[1] = 1'b1;
        p[6:2] = internal_event;
        p[14] = 1'b1;
        p[18] = digital_input_one;
        p[19] = digital_input_two;
        p[28:26] = internal_contact;
        p[37:34] = comm_input;
        p[38] = manual_mode;
        p[39] = ready_mode;
        return (c < 40) ? p[c] : 1'b0;
    endfunction

    function automatic logic comb_m(int s, logic a, b, c, d);
        case (s)
            3: return (a & b) | (c & d);
            4: return (a | b) & (c | d);
            5: return a | b | c | d;
            default: return a & b & c & d;
        endcase
    endfunction

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        int s, hi, e0, m0;
        logic [5:0] sl [4];
        logic [11:0] ta [5];
        int tv [5], te [5];
        void'($urandom(34666));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, do_route_pkg::CYCLE1_OFS, 0, rd);
        check(rd, 32'(do_route_pkg::CYC_RST_RELAY));
        apb(0, do_route_pkg::CYCLE2_OFS, 0, rd);
        check(rd, 32'(do_route_pkg::CYC_RST_PLAIN));
        apb(0, do_route_pkg::SOURCE_OFS, 0, rd);
        check(rd, 0);
        $display("Test reset values done");
        ta = '{do_route_pkg::CYCLE1_OFS, do_route_pkg::CYCLE1_OFS,
               do_route_pkg::CYCLE1_OFS, do_route_pkg::CYCLE2_OFS,
               do_route_pkg::CYCLE2_OFS};
        tv = '{4, 121, 5, 0, 1};
        te = '{10, 10, 5, 2, 1};
        for (int i = 0; i < 5; i++) begin
            apb(1, ta[i], tv[i], rd);
            apb(0, ta[i], 0, rd);
            check(rd, te[i]);
        end
        apb(1, 12'h100, 32'h00000055, rd);
        apb(0, 12'h100, 0, rd);
        check(rd, 0);
        $display("Test cycle limits done");
        apb(1, do_route_pkg::DEMAND_OFS, 32'h00000064, rd);
        for (int i = 0; i < 42; i++) begin
            sl[0] = 6'(i);
            for (int j = 1; j < 4; j++) begin
                sl[j] = 6'($urandom % 42);
            end
            s = 3 + i % 4;
            internal_event <= 5'($urandom);
            internal_contact <= 3'($urandom);
            comm_input <= 4'($urandom);
            {digital_input_one, digital_input_two} <= 2'($urandom);
            {manual_mode, ready_mode} <= 2'($urandom);
            apb(1, do_route_pkg::SLOT_BASE_OFS + 12'h008,
                {8'h00, sl[3], sl[2], sl[1], sl[0]}, rd);
            apb(1, do_route_pkg::SOURCE_OFS, 32'(s) << 6, rd);
            repeat (6) @(posedge pclk);
            check(event_out[0], comb_m(s, slot_m(sl[0]), slot_m(sl[1]),
                slot_m(sl[2]), slot_m(sl[3])));
            check(control_out, 2'b01);
            check(event_out[2:1], internal_event[2:1]);
        end
        apb(1, do_route_pkg::SOURCE_OFS, 32'h0000000a, rd);
        repeat (4) @(posedge pclk);
        check(control_out, 2'b10);
        $display("Test routing done");
        apb(1, do_route_pkg::SOURCE_OFS, 0, rd);
        apb(1, do_route_pkg::DEMAND_OFS, 32'h0000001e, rd);
        repeat (1000) @(posedge pclk);
        hi = 0;
        repeat (5 * 100 * TICKS) begin
            @(posedge pclk);
            hi += control_out[0];
        end
        check(32'(hi >= 297 && hi <= 303), 1);
        apb(1, do_route_pkg::MODE_OFS, 1, rd);
        apb(1, do_route_pkg::DEMAND_OFS, 32'h0000321e, rd);
        apb(1, do_route_pkg::SOURCE_OFS, 32'h00000280, rd);
        repeat (1000) @(posedge pclk);
        e0 = on_count[2];
        m0 = on_count[0];
        repeat (2000) @(posedge pclk);
        check(32'(on_count[2] - e0 inside {[1:3]}), 1);
        check(32'(on_count[0] - m0 inside {[1:3]}), 1);
        $display("Test cycle timing done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        {out1_relay, out2_relay, single_var} <= 3'b011;
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, do_route_pkg::CYCLE1_OFS, 0, rd);
        check(rd, 32'(do_route_pkg::CYC_RST_PLAIN));
        apb(0, do_route_pkg::CYCLE2_OFS, 0, rd);
        check(rd, 32'(do_route_pkg::CYC_RST_RELAY));
        apb(1, do_route_pkg::CYCLE2_OFS, 3, rd);
        apb(0, do_route_pkg::CYCLE2_OFS, 0, rd);
        check(rd, 32'(do_route_pkg::CYC_RST_RELAY));
        apb(1, do_route_pkg::CYCLE1_OFS, 1, rd);
        apb(0, do_route_pkg::CYCLE1_OFS, 0, rd);
        check(rd, 1);
        $display("Test strap reset done");
        conclude();
    end
endmodule
